/* design/gas_pkg.sv */
// shared constants, types and the character channel of the polled responder
package gas_pkg;
   // clock, character frame and reply timing
   localparam int CLK_HZ = 20_000_000;
   localparam int BAUD_DEF = 9600;
   localparam int BAUD_DIV_DEF = CLK_HZ / BAUD_DEF;
   localparam int DATA_BITS = 7;
   localparam int STOP_BITS = 2;
   localparam int RESP_DELAY_MS = 200;
   localparam int RESP_DELAY_CYC = (CLK_HZ / 1000) * RESP_DELAY_MS;
   // register byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ID = 8'h04;
   localparam logic [7:0] REG_GAS = 8'h08;
   localparam logic [7:0] REG_UNITS = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [1:0] REG_MAP_PAGE = 2'h1;
   // control fields
   localparam int CTRL_EN_LSB = 0;
   localparam int CTRL_VAR_BIT = 2;
   localparam int CTRL_FMT_LSB = 3;
   localparam int STAT_MODE_LSB = 16;
   // reset values; ids are three bcd digits
   localparam logic [1:0] EN_RST = 2'h0;
   localparam logic [11:0] ID_RST = 12'h360;
   localparam logic [11:0] GAS_RST = 12'h310;
   localparam logic [1:0] UNITS_RST = 2'h3;
   localparam int NFLAGS = 16;
   localparam logic [15:0][15:0] MAP_RST = {
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0800, 16'h0400, 16'h0200, 16'h0100,
      16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0001};
   localparam int FLAG_ZERO = 10;
   localparam int FLAG_SPAN = 11;
   // units code sits in status bits 14:13
   localparam int UNITS_LSB = 13;
   localparam logic [15:0] UNITS_MASK = 16'h6000;
   typedef enum logic [1:0] {U_MICRO = 2'h0, U_MILLI = 2'h1, U_PPB = 2'h2, U_PPM = 2'h3} units_t;
   typedef enum logic [1:0] {FMT_CMD = 2'h0, FMT_CHK = 2'h1, FMT_CR = 2'h2} fmt_t;
   typedef enum logic [1:0] {MODE_MEASURE = 2'h0, MODE_ZERO = 2'h1, MODE_SPAN = 2'h2} mode_t;
   // characters and command letters
   localparam logic [6:0] CH_STX = 7'h02;
   localparam logic [6:0] CH_ETX = 7'h03;
   localparam logic [6:0] CH_CR = 7'h0d;
   localparam logic [6:0] CMD_STATUS = 7'h53;
   localparam logic [6:0] CMD_ZERO = 7'h5a;
   localparam logic [6:0] CMD_SPAN = 7'h50;
   localparam logic [6:0] CMD_MEASURE = 7'h4d;
   localparam int BODY_T1 = 12;
   localparam int BODY_T2 = 15;

   // one nibble as an ascii hex digit
   function automatic logic [6:0] hex_char(input logic [3:0] n);
      if (n < 4'ha) begin
         hex_char = {3'h3, n};
      end else begin
         hex_char = 7'(7'h37 + {3'h0, n});
      end
   endfunction
endpackage

`timescale 1ns/1ps
// one received or transmitted character between core and serial framer
interface char_if;
   logic rx_valid;
   logic [6:0] rx_data;
   logic tx_valid;
   logic [6:0] tx_data;
   logic tx_ready;
   modport core (output rx_valid, output rx_data, output tx_ready, input tx_valid, input tx_data);
   modport user (input rx_valid, input rx_data, input tx_ready, output tx_valid, output tx_data);
endinterface

/* design/status_word.sv */
`timescale 1ns/1ps
// status word builder: or of assigned flag groups plus the units code
module status_word
   import gas_pkg::*;
(
   // condition flags and their bit assignments
   input wire logic [gas_pkg::NFLAGS-1:0] flags_i,
   input wire logic [gas_pkg::NFLAGS-1:0][15:0] map_i,
   input wire logic [1:0] units_i,
   // assembled word
   output logic [15:0] word_o
);
   // unmapped flags carry an all-zero mask and so never set a bit
   always_comb begin
      logic [15:0] w;
      w = 16'h0000;
      for (int i = 0; i < NFLAGS; i++) begin
         if (flags_i[i]) begin
            w = w | map_i[i]; // R16 R17
         end
      end
      word_o = (w & ~UNITS_MASK) | ({14'h0000, units_i} << UNITS_LSB); // R15
   end
endmodule

/* design/serial_7e2.sv */
`timescale 1ns/1ps
// half duplex character framer: start, 7 data, even parity, 2 stops
module serial_7e2 #(
   parameter int BAUD_DIV = gas_pkg::BAUD_DIV_DEF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // line
   input wire logic en_i,
   input wire logic rxd_i,
   output logic txd_o,
   output logic txd_oe_o,
   // character side
   char_if.core ch
);
   import gas_pkg::*;
   localparam int FRAME = DATA_BITS + 1 + STOP_BITS;

   initial begin
      if (BAUD_DIV < 4 || BAUD_DIV > 65535) $error("BAUD_DIV out of range");
   end

   typedef struct packed {
      logic rx_busy;
      logic [15:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [9:0] rx_sh;
      logic rx_valid;
      logic [6:0] rx_data;
      logic tx_busy;
      logic [15:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [10:0] tx_sh;
      logic txd;
   } ser_t;
   ser_t s, next_s;

   // receiver samples mid-bit, transmitter shifts lsb first
   always_comb begin
      logic [9:0] shn;
      shn = {rxd_i, s.rx_sh[9:1]};
      next_s = s;
      next_s.rx_valid = 1'b0;
      // half duplex: listening stops while this end drives the line
      if (!s.rx_busy) begin
         if (en_i && !s.tx_busy && !rxd_i) begin // R4
            next_s.rx_busy = 1'b1;
            next_s.rx_cnt = 16'(BAUD_DIV / 2);
            next_s.rx_bit = 4'h0;
         end
      end else if (s.rx_cnt != 16'h0000) begin
         next_s.rx_cnt = s.rx_cnt - 16'h0001;
      end else begin
         next_s.rx_cnt = 16'(BAUD_DIV - 1);
         if (s.rx_bit == 4'h0) begin
            next_s.rx_busy = !rxd_i;
            next_s.rx_bit = 4'h1;
         end else begin
            next_s.rx_sh = shn;
            next_s.rx_bit = s.rx_bit + 4'h1;
            if (s.rx_bit == 4'(FRAME)) begin
               next_s.rx_busy = 1'b0;
               // bad parity or a missing stop bit drops the character
               next_s.rx_valid = (^shn[7:0] == 1'b0) && (shn[9:8] == 2'b11); // R4
               next_s.rx_data = shn[6:0];
            end
         end
      end
      if (!s.tx_busy) begin
         next_s.txd = 1'b1;
         if (ch.tx_valid) begin
            next_s.tx_busy = 1'b1;
            next_s.tx_sh = {2'b11, ^ch.tx_data, ch.tx_data, 1'b0}; // R4
            next_s.txd = 1'b0;
            next_s.tx_cnt = 16'(BAUD_DIV - 1);
            next_s.tx_bit = 4'h0;
         end
      end else if (s.tx_cnt != 16'h0000) begin
         next_s.tx_cnt = s.tx_cnt - 16'h0001;
      end else begin
         next_s.tx_cnt = 16'(BAUD_DIV - 1);
         next_s.tx_bit = s.tx_bit + 4'h1;
         next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
         next_s.txd = s.tx_sh[1];
         if (s.tx_bit == 4'(FRAME)) begin
            next_s.tx_busy = 1'b0;
            next_s.txd = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.txd <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign txd_o = s.txd;
   assign txd_oe_o = s.tx_busy;
   assign ch.tx_ready = !s.tx_busy;
   assign ch.rx_valid = s.rx_valid;
   assign ch.rx_data = s.rx_data;

   tx_frame_even_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      ch.tx_valid && !s.tx_busy |=> (^s.tx_sh[8:1] == 1'b0) && s.tx_sh[10:9] == 2'b11)
      else $error("transmit frame not even parity with two stops");
endmodule

/* design/gas_responder.sv */
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
// polled multidrop responder: command decode, reply framing, registers
// Operation
// (R1) act only on commands whose address digits equal our instrument id
// (R2) transmit only as a reply to an accepted host command
// (R3) report status and concentration; switch to zero, span or measure
// (R4) both ends use 7 data bits, even parity, 2 stops, half duplex
// (R5) wait about 200 ms after a command before starting the reply
// (R6) host spaces commands to one instrument by the reply latency
// (R7) protocol enabled separately for each of the two serial ports
// (R8) one variant setting, type 1 or 2, serves both ports
// (R9) default format frames each reply as the triggering command was framed
// (R10) checksum format: stx, body, etx, then two check digits
// (R11) carriage return format: reply starts and ends with cr
// (R12) replies carry a status word built from assignable flags
// (R13) default warning flags map to bits 0001 through 0080
// (R14) default operational flags map to bits 0100 through 0800
// (R15) units code in status: 0000, 2000, 4000, 6000
// (R16) unassigned flags map to no status bit
// (R17) a status bit is the or of all flags assigned to it
// (R18) default gas identifier is 310
// (R19) configurable instrument id, default 360
// (R20) check code is the xor of reply characters between delimiters, two hex digits
module gas_responder
   import gas_pkg::*;
#(
   parameter int RESP_DELAY = gas_pkg::RESP_DELAY_CYC,
   parameter int BAUD_DIV = gas_pkg::BAUD_DIV_DEF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // serial lines, index 0 first_serial_port, index 1 second_serial_port
   input wire logic [1:0] rxd_i,
   output logic [1:0] txd_o,
   output logic [1:0] txd_oe_o,
   // instrument side
   input wire logic [gas_pkg::NFLAGS-1:0] flags_i,
   input wire logic [15:0] conc_i,
   output logic [1:0] mode_o
);
   localparam int DW = $clog2(RESP_DELAY + 1);

   initial begin
      if (RESP_DELAY < 1) $error("RESP_DELAY must be at least one cycle");
   end

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_RECV = 4'b0010,
      ST_WAIT = 4'b0100,
      ST_SEND = 4'b1000
   } state_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [1:0] port_en;
      logic var2;
      fmt_t fmt;
      logic [11:0] id;
      logic [11:0] gas;
      logic [1:0] units;
      logic [NFLAGS-1:0][15:0] map;
      state_t st;
      logic port;
      logic framed;
      logic [6:0] cmd;
      logic [1:0] pos;
      logic id_ok;
      logic [DW-1:0] dly;
      logic [4:0] idx;
      logic [6:0] xsum;
      logic [15:0] snap_st;
      logic [15:0] snap_conc;
      logic tx_valid;
      logic [6:0] tx_data;
      mode_t mode;
   } core_t;
   core_t q, next_q;

   char_if ch[2] ();
   logic [1:0] rx_v;
   logic [1:0][6:0] rx_d;
   logic [1:0] tx_rdy;
   logic [15:0] st_word;
   logic [NFLAGS-1:0] flags_eff;

   // one framer per port, each enabled on its own
   for (genvar p = 0; p < 2; p++) begin : g_port
      serial_7e2 #(.BAUD_DIV(BAUD_DIV)) u_ser (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .en_i(q.port_en[p]), // R7
         .rxd_i(rxd_i[p]),
         .txd_o(txd_o[p]),
         .txd_oe_o(txd_oe_o[p]),
         .ch(ch[p])
      );
      assign rx_v[p] = ch[p].rx_valid;
      assign rx_d[p] = ch[p].rx_data;
      assign tx_rdy[p] = ch[p].tx_ready;
      assign ch[p].tx_valid = q.tx_valid && (q.port == 1'(p)); // R2
      assign ch[p].tx_data = q.tx_data;
   end

   // the commanded calibration modes also raise their operational flags
   always_comb begin
      flags_eff = flags_i;
      flags_eff[FLAG_ZERO] = flags_i[FLAG_ZERO] || (q.mode == MODE_ZERO); // R14
      flags_eff[FLAG_SPAN] = flags_i[FLAG_SPAN] || (q.mode == MODE_SPAN); // R14
   end

   status_word u_status (
      .flags_i(flags_eff),
      .map_i(q.map),
      .units_i(q.units),
      .word_o(st_word)
   );

   // byte-lane merge of a wishbone write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      for (int b = 0; b < 4; b++) begin
         merge[8*b +: 8] = sel[b] ? d[8*b +: 8] : old[8*b +: 8];
      end
   endfunction

   // one reply body character; type 2 adds the gas id field
   function automatic logic [6:0] body_char(input logic [4:0] k, input core_t c);
      logic [4:0] cpos;
      cpos = c.var2 ? 5'd11 : 5'd8;
      body_char = c.cmd;
      if (k >= 5'd1 && k <= 5'd3) begin
         body_char = hex_char(c.id[4'(4 * (3 - k)) +: 4]);
      end else if (k >= 5'd4 && k <= 5'd7) begin
         body_char = hex_char(c.snap_st[4'(4 * (7 - k)) +: 4]); // R12
      end else if (c.var2 && k >= 5'd8 && k <= 5'd10) begin
         body_char = hex_char(c.gas[4'(4 * (10 - k)) +: 4]); // R8 R18
      end else if (k >= cpos) begin
         body_char = hex_char(c.snap_conc[4'(4 * (3 - (k - cpos))) +: 4]); // R3
      end
   endfunction

   // decode, timing and reply sequencing
   always_comb begin
      logic [31:0] old;
      logic [31:0] nw;
      logic hit;
      logic [6:0] c;
      logic chk;
      logic [4:0] blen;
      logic [4:0] last;
      old = 32'h0000_0000;
      nw = 32'h0000_0000;
      hit = 1'b0;
      c = rx_d[q.port];
      next_q = q;
      next_q.tx_valid = 1'b0;
      // classic single cycle: ack one cycle after strobe, dropped next cycle
      next_q.ack = wb_cyc_i && wb_stb_i && !q.ack;
      unique case (wb_adr_i)
         REG_CTRL: old = {27'h0, q.fmt, q.var2, q.port_en};
         REG_ID: old = {20'h0, q.id};
         REG_GAS: old = {20'h0, q.gas};
         REG_UNITS: old = {30'h0, q.units};
         REG_STATUS: old = {14'h0, q.mode, st_word};
         default: begin
            if (wb_adr_i[7:6] == REG_MAP_PAGE) begin
               old = {16'h0, q.map[wb_adr_i[5:2]]};
            end
         end
      endcase
      next_q.rdat = old;
      nw = merge(old, wb_dat_i, wb_sel_i);
      if (wb_cyc_i && wb_stb_i && wb_we_i && !q.ack) begin
         unique case (wb_adr_i)
            REG_CTRL: begin
               next_q.port_en = nw[CTRL_EN_LSB +: 2]; // R7
               next_q.var2 = nw[CTRL_VAR_BIT]; // R8
               next_q.fmt = fmt_t'(nw[CTRL_FMT_LSB +: 2]);
            end
            REG_ID: next_q.id = nw[11:0]; // R19
            REG_GAS: next_q.gas = nw[11:0];
            REG_UNITS: next_q.units = nw[1:0]; // R15
            default: begin
               if (wb_adr_i[7:6] == REG_MAP_PAGE) begin
                  next_q.map[wb_adr_i[5:2]] = nw[15:0]; // R12
               end
            end
         endcase
      end
      // reply framing follows the format, or the command in default format
      chk = (q.fmt == FMT_CHK) || (q.fmt == FMT_CMD && q.framed); // R9 R10
      blen = q.var2 ? 5'(BODY_T2) : 5'(BODY_T1);
      last = chk ? 5'(blen + 5'd3) : 5'(blen + 5'd1);
      unique case (q.st)
         ST_IDLE: begin
            if (rx_v[0] && q.port_en[0]) begin
               hit = 1'b1;
               next_q.port = 1'b0;
            end else if (rx_v[1] && q.port_en[1]) begin
               hit = 1'b1;
               next_q.port = 1'b1;
            end
            c = rx_d[next_q.port];
            if (hit) begin
               next_q.framed = (c == CH_STX);
               if (c == CMD_STATUS || c == CMD_ZERO || c == CMD_SPAN || c == CMD_MEASURE) begin
                  next_q.framed = q.framed;
                  next_q.cmd = c;
                  next_q.pos = 2'h0;
                  next_q.id_ok = 1'b1;
                  next_q.st = ST_RECV;
               end
            end
         end
         ST_RECV: begin
            if (rx_v[q.port]) begin
               next_q.pos = q.pos + 2'h1;
               if (q.pos != 2'h3) begin
                  if (c != hex_char(q.id[4'(4 * (2 - q.pos)) +: 4])) begin
                     next_q.id_ok = 1'b0; // R1
                  end
               end else if ((c == CH_CR || c == CH_ETX) && q.id_ok) begin
                  next_q.st = ST_WAIT; // R1
                  next_q.dly = DW'(RESP_DELAY - 1);
                  unique case (q.cmd)
                     CMD_ZERO: next_q.mode = MODE_ZERO; // R3
                     CMD_SPAN: next_q.mode = MODE_SPAN; // R3
                     CMD_MEASURE: next_q.mode = MODE_MEASURE; // R3
                     default: next_q.mode = q.mode;
                  endcase
               end else begin
                  next_q.st = ST_IDLE; // R1
                  next_q.framed = 1'b0;
               end
            end
         end
         ST_WAIT: begin
            // latency before the reply; host must not poll faster
            if (q.dly != '0) begin
               next_q.dly = q.dly - DW'(1); // R5
            end else begin
               next_q.st = ST_SEND;
               next_q.idx = 5'd0;
               next_q.xsum = 7'h00;
               next_q.snap_st = st_word; // R12
               next_q.snap_conc = conc_i;
            end
         end
         ST_SEND: begin
            // ready lags valid by a cycle, so a pending valid blocks the next
            if (tx_rdy[q.port] && !q.tx_valid) begin
               if (q.idx > last) begin
                  next_q.st = ST_IDLE;
                  next_q.framed = 1'b0;
               end else begin
                  next_q.tx_valid = 1'b1; // R2
                  next_q.idx = q.idx + 5'd1;
                  if (q.idx == 5'd0) begin
                     next_q.tx_data = chk ? CH_STX : CH_CR; // R10 R11
                  end else if (q.idx <= blen) begin
                     next_q.tx_data = body_char(5'(q.idx - 5'd1), q);
                     next_q.xsum = q.xsum ^ next_q.tx_data; // R20
                  end else if (q.idx == 5'(blen + 5'd1)) begin
                     next_q.tx_data = chk ? CH_ETX : CH_CR; // R10 R11
                  end else if (q.idx == 5'(blen + 5'd2)) begin
                     next_q.tx_data = hex_char({1'b0, q.xsum[6:4]}); // R20
                  end else begin
                     next_q.tx_data = hex_char(q.xsum[3:0]); // R20
                  end
               end
            end
         end
         default: next_q.st = ST_IDLE;
      endcase
   end

   // everything resets to its documented default
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.port_en <= EN_RST;
         q.fmt <= FMT_CMD;
         q.id <= ID_RST; // R19
         q.gas <= GAS_RST; // R18
         q.units <= UNITS_RST;
         q.map <= MAP_RST; // R13 R14 R16
         q.mode <= MODE_MEASURE;
      end else begin
         q <= next_q;
      end
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdat;
   assign mode_o = q.mode;

   // helper: cycles spent waiting since the command was accepted
   logic [DW:0] waited;
   always_ff @(posedge clk_i) begin
      if (rst_i || q.st != ST_WAIT) begin
         waited <= '0;
      end else begin
         waited <= waited + (DW + 1)'(1);
      end
   end

   ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   tx_only_reply_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      q.tx_valid |-> $past(q.st) == ST_SEND)
      else $error("character sent outside a reply");
   reply_delay_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      q.st == ST_WAIT && next_q.st == ST_SEND |-> waited == (DW + 1)'(RESP_DELAY - 1))
      else $error("reply started before latency elapsed");
   foreign_id_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
      q.st == ST_RECV && q.pos == 2'h3 && !q.id_ok && rx_v[q.port] |=> q.st == ST_IDLE)
      else $error("command for another id was acted on");
   zero_mode_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
      q.st == ST_RECV && next_q.st == ST_WAIT && q.cmd == CMD_ZERO |=> mode_o == MODE_ZERO)
      else $error("zero command did not enter zero mode");
   chk_open_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
      q.st == ST_SEND && q.fmt == FMT_CHK && q.tx_valid && q.idx == 5'd1 |-> q.tx_data == CH_STX)
      else $error("checksum reply does not open with stx");
   cr_open_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      q.st == ST_SEND && q.fmt == FMT_CR && q.tx_valid && q.idx == 5'd1 |-> q.tx_data == CH_CR)
      else $error("cr reply does not open with cr");
   port_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
      q.st == ST_IDLE && next_q.st == ST_RECV |-> q.port_en[next_q.port])
      else $error("command taken on a disabled port");
   status_or_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
      flags_eff[0] |-> (st_word & q.map[0] & ~UNITS_MASK) == (q.map[0] & ~UNITS_MASK))
      else $error("assigned flag did not set its status bit");
endmodule

/* sim/host_model.sv */
// host computer on the multidrop line: sends commands, collects reply characters
`timescale 1ns/1ps
module host_model #(
   parameter int BD = 8
) (
   // clock
   input wire logic clk_i,
   // device lines
   input wire logic [1:0] txd_i,
   output logic [1:0] rxd_o
);
   logic [7:0] got[$];
   int bad = 0;

   // line idles at mark between frames
   initial rxd_o = 2'h3;

   // one frame: start, 7 data lsb first, even parity, 2 stops
   task automatic send_ch(input int p, input logic [6:0] c);
      logic [10:0] f;
      f = {2'h3, ^c, c, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd_o[p] <= f[i];
         repeat (BD) @(posedge clk_i);
      end
   endtask

   // whole command; caller waits for the reply before the next one
   task automatic send_str(input int p, input string s);
      foreach (s[i]) send_ch(p, 7'(s[i]));
   endtask

   // mid-bit sampling of each device frame; bad framing is counted
   for (genvar p = 0; p < 2; p++) begin : g_rx
      initial forever begin
         logic [10:0] f;
         @(negedge txd_i[p]);
         repeat (BD / 2) @(posedge clk_i);
         for (int i = 0; i < 11; i++) begin
            f[i] = txd_i[p];
            if (i < 10) repeat (BD) @(posedge clk_i);
         end
         if (f[0] || f[10:9] != 2'h3 || ^f[8:1]) bad++;
         got.push_back({1'(p), f[7:1]});
      end
   end
endmodule

/* sim/tb_top.sv */
// self-checking bench for the polled responder
`timescale 1ns/1ps
module tb_top;
   import gas_pkg::*;
   localparam int BD = 8;
   localparam int DLY = 20;
   logic clk_i = 0;
   logic rst_i = 1;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_we_i = 0;
   logic wb_cyc_i = 0;
   logic wb_stb_i = 0;
   logic wb_ack_o;
   logic [1:0] rxd_i, txd_o, txd_oe_o, mode_o;
   logic [15:0] flags_i = 16'h0;
   logic [15:0] conc_i = 16'h1a2f;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;

   gas_responder #(.RESP_DELAY(DLY), .BAUD_DIV(BD)) i_gas_responder (.clk_i(clk_i),
      .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf),
      .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .rxd_i(rxd_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o),
      .flags_i(flags_i), .conc_i(conc_i), .mode_o(mode_o));
   host_model #(.BD(BD)) i_host_model (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

   // 20 mhz clock
   initial forever #25 clk_i = ~clk_i;

   // hang guard, well above the whole sequence
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 40000) begin
         num_errors++;
         tally_and_finish;
      end
   end

   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask

   // classic cycle: hold until ack is sampled, then release for a cycle
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= d;
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(a, 1, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] q;
      wb(a, 0, 32'h0, q);
      check(n, q, e);
   endtask

   function automatic logic [6:0] hx(input logic [3:0] n);
      return 7'(n) + (n < 4'ha ? 7'h30 : 7'h37);
   endfunction

   // send a command, build the reply it must bring, compare char by char
   task automatic cmd(input int p, input string s, input bit ok, input bit chk,
                      input bit t2, input logic [15:0] st);
      logic [6:0] b[$];
      logic [6:0] e[$];
      logic [6:0] x;
      int n;
      int lat;
      lat = -1;
      i_host_model.got = {};
      i_host_model.send_str(p, s);
      if (ok) begin
         b = {7'(s[s.len() - 5]), 7'h33, 7'h36, 7'h30};
         b = {b, hx(st[15:12]), hx(st[11:8]), hx(st[7:4]), hx(st[3:0])};
         if (t2) b = {b, 7'h33, 7'h31, 7'h30};
         b = {b, hx(conc_i[15:12]), hx(conc_i[11:8]), hx(conc_i[7:4]), hx(conc_i[3:0])};
         x = 7'h0;
         foreach (b[i]) x ^= b[i];
         if (chk) e = {CH_STX, b, CH_ETX, hx({1'b0, x[6:4]}), hx(x[3:0])};
         else e = {CH_CR, b, CH_CR};
      end
      // cycles from the end of the command to the first reply frame
      for (n = 0; n < (ok ? 4000 : 600); n++) begin
         if (ok && i_host_model.got.size() == e.size()) break;
         if (lat < 0 && txd_oe_o[p] === 1'b1) lat = n;
         @(posedge clk_i);
      end
      if (ok) check("reply latency", 32'(lat >= DLY && lat <= DLY + 4), 32'h1);
      // let the last stop bits finish before the next poll
      repeat (4 * BD) @(posedge clk_i);
      check("reply length", i_host_model.got.size(), e.size());
      foreach (e[i]) check("reply char", i_host_model.got[i], {1'(p), e[i]});
      check("line released", txd_oe_o, 32'h0);
      check("frame faults", i_host_model.bad, 32'h0);
   endtask

   task automatic t_defaults;
      rd(REG_ID, 32'h360, "instrument id");
      rd(REG_GAS, 32'h310, "gas id");
      rd(REG_CTRL, 32'h0, "control");
      rd(REG_UNITS, 32'h3, "units");
      for (int i = 0; i < 16; i++) rd(8'h40 + 8'(4 * i), i < 12 ? 32'h1 << i : 0, "map");
      wr(8'h30, 32'hff);
      rd(8'h30, 32'h0, "unmapped");
   endtask

   task automatic t_status;
      flags_i <= 16'hf000;
      for (int u = 0; u < 4; u++) begin
         wr(REG_UNITS, 32'(u));
         rd(REG_STATUS, 32'(u) << 13, "units code");
      end
      wr(8'h44, 32'h1);
      flags_i <= 16'h0002;
      rd(REG_STATUS, 32'h6001, "shared bit");
      flags_i <= 16'h0003;
      rd(REG_STATUS, 32'h6001, "shared bit both");
      wr(8'h44, 32'h2);
      flags_i <= 16'h1005;
      rd(REG_STATUS, 32'h6005, "status word");
   endtask

   task automatic t_link;
      cmd(0, "S360\r", 0, 0, 0, 16'h0);
      wr(REG_CTRL, 32'h1);
      cmd(1, "S360\r", 0, 0, 0, 16'h0);
      cmd(0, "S361\r", 0, 0, 0, 16'h0);
      cmd(0, "S360\r", 1, 0, 0, 16'h6005);
      wr(REG_CTRL, 32'h0e);
      cmd(1, "Z360\r", 1, 1, 1, 16'h6405);
      check("zero mode", mode_o, 32'h1);
      wr(REG_CTRL, 32'h3);
      cmd(0, "\x02M360\x03", 1, 1, 0, 16'h6005);
      check("measure mode", mode_o, 32'h0);
      wr(REG_CTRL, 32'h12);
      cmd(1, "\x02P360\x03", 1, 0, 0, 16'h6805);
      check("span mode", mode_o, 32'h2);
   endtask

   task automatic tally_and_finish;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // reset for 20 cycles, then the scenarios in turn
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      t_defaults;
      t_status;
      t_link;
      tally_and_finish;
   end
endmodule
